// ===== src/tcs_pkg.sv
// Package with register map, field layout, reset values and divider constants of the timer unit.
package tcs_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] CTRL0_OFS = 8'h00;
	localparam logic [7:0] CTRL1_OFS = 8'h04;
	localparam logic [7:0] CTRL2_OFS = 8'h08;
	localparam logic [7:0] MODE0_OFS = 8'h0C;
	localparam logic [7:0] MODE1_OFS = 8'h10;
	localparam logic [7:0] MODE2_OFS = 8'h14;
	localparam logic [7:0] RUN_OFS = 8'h18;
	localparam logic [7:0] SYNC_OFS = 8'h1C;
	localparam logic [7:0] CNT0_OFS = 8'h20;
	localparam logic [7:0] CNT1_OFS = 8'h24;
	localparam logic [7:0] CNT2_OFS = 8'h28;
	localparam logic [7:0] GR_BASE_OFS = 8'h30;
	localparam logic [7:0] IOC_BASE_OFS = 8'h50;
	localparam logic [7:0] PIN_STAT_OFS = 8'h60;

	// ==========================================================
	// Sizes and field positions
	localparam int NUM_CH = 3;
	localparam int NUM_GR = 8;
	localparam int NUM_IOC = 4;
	localparam int CNT_W = 16;
	localparam int CLR_HI = 7;
	localparam int CLR_LO = 5;
	localparam int EDGE_HI = 4;
	localparam int EDGE_LO = 3;
	localparam int SEL_HI = 2;
	localparam int SEL_LO = 0;
	localparam int MODE_PHASE_BIT = 0;
	localparam int IOC_OE_LO = 0;
	localparam int IOC_OE_HI = 4;

	// ==========================================================
	// Reset values and reserved-bit mask
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] IOC_RST = 8'h00;
	localparam logic [2:0] RUN_RST = 3'h0;
	localparam logic [2:0] SYNC_RST = 3'h0;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] GR_RST = 16'hFFFF;
	localparam logic [7:0] RESERVED_BIT7_MASK = 8'h7F;

	// ==========================================================
	// Prescaler taps: divide by 4, 16, 64, 256 and 1024
	localparam int NUM_DIV = 5;
	localparam int DIV_W = 10;
	localparam logic [9:0] DIV_MASK [5] = '{10'h003, 10'h00F, 10'h03F, 10'h0FF, 10'h3FF};
	localparam int DIV4 = 0;
	localparam int DIV16 = 1;
	localparam int DIV64 = 2;
	localparam int DIV256 = 3;
	localparam int DIV1024 = 4;

	// ==========================================================
	// Clear-source codes
	localparam logic [2:0] CLR_A = 3'h1;
	localparam logic [2:0] CLR_B = 3'h2;
	localparam logic [2:0] CLR_SYNC = 3'h3;
	localparam logic [2:0] CLR_C = 3'h5;
	localparam logic [2:0] CLR_D = 3'h6;
	localparam logic [2:0] CLR_SYNC2 = 3'h7;

endpackage

// ===== src/tcs_prescaler.sv
// Free-running divider that gives rise and fall pulses of the divided system clocks.
`timescale 1ns/1ns
module tcs_prescaler
(
	input wire logic pclk,
	input wire logic presetn,
	output logic [4:0] div_rise,
	output logic [4:0] div_fall
);

	typedef struct packed
	{
		logic [9:0] cnt;
	} tcs_pre_state_t;

	tcs_pre_state_t r;
	tcs_pre_state_t n;

	always_comb
	begin
		n = r;
		n.cnt = r.cnt + 10'h001;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '0;
		else
			r <= n;
	end

	// ==========================================================
	// Taps
	// The divided clock falls when its low bits wrap and rises at the half way point.
	for (genvar i = 0; i < tcs_pkg::NUM_DIV; i++)
	begin : g_tap
		assign div_rise[i] = (r.cnt & tcs_pkg::DIV_MASK[i]) == (tcs_pkg::DIV_MASK[i] >> 1);
		assign div_fall[i] = (r.cnt & tcs_pkg::DIV_MASK[i]) == tcs_pkg::DIV_MASK[i];
	end

endmodule

// ===== src/tcs_ext_sync.sv
// Two-stage synchroniser and edge detector for the four external clock inputs.
`timescale 1ns/1ns
module tcs_ext_sync
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] ext_in,
	output logic [3:0] ext_level,
	output logic [3:0] ext_rise,
	output logic [3:0] ext_fall
);

	typedef struct packed
	{
		logic [3:0] meta;
		logic [3:0] sync;
		logic [3:0] last;
	} tcs_sync_state_t;

	tcs_sync_state_t r;
	tcs_sync_state_t n;

	always_comb
	begin
		n = r;
		n.meta = ext_in;
		n.sync = r.meta;
		n.last = r.sync;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '0;
		else
			r <= n;
	end

	// Only the second and third stages feed the edge logic.
	assign ext_level = r.sync;
	assign ext_rise = r.sync & ~r.last;
	assign ext_fall = ~r.sync & r.last;

endmodule

// ===== src/tcs_timer.sv
// Three-channel timer with per-channel clock, edge and clear-source control over APB.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns

// How it works
// R1: Three independent channels, each with control register.
// R2: Software changes control only while halted; the control write is accepted while a channel runs too.
// R3: Bits 7:5 choose the counter clear event.
// R4: Bits 4:3: rising, falling, or both edges.
// R5: Both edges count twice per input period.
// R6: Phase counting mode ignores the edge field.
// R7: Undivided clock counts every cycle, edge ignored.
// R8: Bits 2:0 pick clock, per channel independently.
// R9: External inputs A/B clock all, phase ch1.
// R10: External inputs C/D clock, phase ch2.
// R11: Channel 0 has four bidirectional pins A-D.
// R12: Channels 1 and 2 have pins A, B.
// R13: Channel 0 four general, two I/O regs.
// R14: Shared run-control and sync-control registers.
// R15: Clear codes: none, A, B, C, D, sync.
// R16: Codes 0-3 divide 1/4/16/64, 4-7 external.
// R17: Ch1 110 is /256; ch2 110 C, 111 /1024.
// R18: Channels 1, 2 bit 7 reads zero.
// R19: External clocks synchronised and edge detected first.
module tcs_timer
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_clock_in_a,
	input wire logic ext_clock_in_b,
	input wire logic ext_clock_in_c,
	input wire logic ext_clock_in_d,
	input wire logic ch0_pin_a_in,
	output logic ch0_pin_a_out,
	output logic ch0_pin_a_oe,
	input wire logic ch0_pin_b_in,
	output logic ch0_pin_b_out,
	output logic ch0_pin_b_oe,
	input wire logic ch0_pin_c_in,
	output logic ch0_pin_c_out,
	output logic ch0_pin_c_oe,
	input wire logic ch0_pin_d_in,
	output logic ch0_pin_d_out,
	output logic ch0_pin_d_oe,
	input wire logic ch1_pin_a_in,
	output logic ch1_pin_a_out,
	output logic ch1_pin_a_oe,
	input wire logic ch1_pin_b_in,
	output logic ch1_pin_b_out,
	output logic ch1_pin_b_oe,
	input wire logic ch2_pin_a_in,
	output logic ch2_pin_a_out,
	output logic ch2_pin_a_oe,
	input wire logic ch2_pin_b_in,
	output logic ch2_pin_b_out,
	output logic ch2_pin_b_oe
);

	typedef struct packed
	{
		logic [2:0][7:0] counter_control;
		logic [2:0][7:0] channel_mode_reg;
		logic [2:0] counter_run_control;
		logic [2:0] channel_sync_control;
		logic [2:0][15:0] channel_counter;
		logic [7:0][15:0] general_reg;
		logic [3:0][7:0] pin_function_control;
		logic [7:0] pin_level;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
	} tcs_state_t;

	tcs_state_t r;
	tcs_state_t n;
	logic [4:0] div_rise;
	logic [4:0] div_fall;
	logic [3:0] ext_level;
	logic [3:0] ext_rise;
	logic [3:0] ext_fall;
	logic [7:0] pin_in;

	// ==========================================================
	// Clock sources
	tcs_prescaler u_prescaler
	(
		.pclk(pclk),
		.presetn(presetn),
		.div_rise(div_rise),
		.div_fall(div_fall)
	);

	tcs_ext_sync u_ext_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.ext_in({ext_clock_in_d, ext_clock_in_c, ext_clock_in_b, ext_clock_in_a}), // R19
		.ext_level(ext_level),
		.ext_rise(ext_rise),
		.ext_fall(ext_fall)
	);

	assign pin_in = {ch2_pin_b_in, ch2_pin_a_in, ch1_pin_b_in, ch1_pin_a_in,
		ch0_pin_d_in, ch0_pin_c_in, ch0_pin_b_in, ch0_pin_a_in};

	// ==========================================================
	// Helpers
	function automatic logic pick_edge(input logic rise, input logic fall, input logic [1:0] edg);
		pick_edge = edg[1] ? (rise | fall) : (edg[0] ? fall : rise); // R4 R5
	endfunction

	// Count-enable pulse for one channel from its clock-select and edge fields.
	function automatic logic count_tick(input logic [2:0] sel, input logic [1:0] edg,
		input int ch, input logic [4:0] pr, input logic [4:0] pf,
		input logic [3:0] er, input logic [3:0] ef);
		case (sel) // R8 R16 R17
			3'h0: count_tick = 1'b1; // R7
			3'h1: count_tick = pick_edge(pr[tcs_pkg::DIV4], pf[tcs_pkg::DIV4], edg);
			3'h2: count_tick = pick_edge(pr[tcs_pkg::DIV16], pf[tcs_pkg::DIV16], edg);
			3'h3: count_tick = pick_edge(pr[tcs_pkg::DIV64], pf[tcs_pkg::DIV64], edg);
			3'h4: count_tick = pick_edge(er[0], ef[0], edg); // R9
			3'h5: count_tick = pick_edge(er[1], ef[1], edg); // R9
			3'h6: count_tick = (ch == 1) ? pick_edge(pr[tcs_pkg::DIV256], pf[tcs_pkg::DIV256], edg)
				: pick_edge(er[2], ef[2], edg); // R10
			3'h7: count_tick = (ch == 0) ? pick_edge(er[3], ef[3], edg)
				: ((ch == 2) ? pick_edge(pr[tcs_pkg::DIV1024], pf[tcs_pkg::DIV1024], edg) : 1'b0);
			default: count_tick = 1'b0;
		endcase
	endfunction

	// Index of a channel's first general register; channel 0 owns four, the others two.
	function automatic int gr_base(input int ch);
		gr_base = (ch == 0) ? 0 : ((ch == 1) ? 4 : 6); // R13
	endfunction

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		logic [2:0] tick;
		logic [2:0] dn;
		logic [2:0] clr_own;
		logic [2:0] clr_sync_sel;
		logic [2:0] clr_out;
		logic [7:0] match;
		logic [2:0] clr;
		logic [1:0] edg;
		logic [1:0] ea;
		logic [1:0] eb;
		logic phase;
		logic up;
		logic down;
		logic [4:0] word;
		int g;
		tick = '0;
		dn = '0;
		clr_own = '0;
		clr_sync_sel = '0;
		clr_out = '0;
		match = '0;
		clr = '0;
		edg = '0;
		ea = '0;
		eb = '0;
		phase = 1'b0;
		up = 1'b0;
		down = 1'b0;
		word = paddr[6:2];
		g = 0;
		n = r;

		for (int k = 0; k < tcs_pkg::NUM_CH; k++) // R1
		begin
			clr = r.counter_control[k][tcs_pkg::CLR_HI:tcs_pkg::CLR_LO]; // R3
			edg = r.counter_control[k][tcs_pkg::EDGE_HI:tcs_pkg::EDGE_LO];
			phase = (k != 0) && r.channel_mode_reg[k][tcs_pkg::MODE_PHASE_BIT];
			tick[k] = count_tick(r.counter_control[k][tcs_pkg::SEL_HI:tcs_pkg::SEL_LO], edg, k,
				div_rise, div_fall, ext_rise, ext_fall);
			if (phase) // R6
			begin
				// Quadrature decode: channel 1 uses inputs A/B, channel 2 uses C/D.
				ea = (k == 1) ? {ext_rise[0], ext_fall[0]} : {ext_rise[2], ext_fall[2]}; // R9 R10
				eb = (k == 1) ? {ext_rise[1], ext_fall[1]} : {ext_rise[3], ext_fall[3]};
				up = (ea[1] & ~ext_level[2 * k - 1]) | (ea[0] & ext_level[2 * k - 1])
					| (eb[1] & ext_level[2 * k - 2]) | (eb[0] & ~ext_level[2 * k - 2]);
				down = (ea[1] & ext_level[2 * k - 1]) | (ea[0] & ~ext_level[2 * k - 1])
					| (eb[1] & ~ext_level[2 * k - 2]) | (eb[0] & ext_level[2 * k - 2]);
				tick[k] = up ^ down;
				dn[k] = down & ~up;
			end
			tick[k] = tick[k] & r.counter_run_control[k]; // R14
			g = gr_base(k);
			for (int j = 0; j < 4; j++)
			begin
				if ((k == 0) || (j < 2))
					match[g + j] = tick[k] && (r.channel_counter[k] == r.general_reg[g + j]);
			end
			case (clr) // R15
				tcs_pkg::CLR_A: clr_own[k] = match[g];
				tcs_pkg::CLR_B: clr_own[k] = match[g + 1];
				tcs_pkg::CLR_C: clr_own[k] = (k == 0) && match[2];
				tcs_pkg::CLR_D: clr_own[k] = (k == 0) && match[3];
				tcs_pkg::CLR_SYNC, tcs_pkg::CLR_SYNC2: clr_sync_sel[k] = 1'b1;
				default: clr_own[k] = 1'b0;
			endcase
		end

		// A synchronised channel set to follow clears when another synchronised channel clears.
		clr_out = clr_own & r.channel_sync_control;
		for (int k = 0; k < tcs_pkg::NUM_CH; k++)
		begin
			if (clr_own[k] || (clr_sync_sel[k] && r.channel_sync_control[k]
				&& ((clr_out & ~(3'h1 << k)) != 3'h0))) // R15
				n.channel_counter[k] = tcs_pkg::CNT_RST;
			else if (tick[k])
				n.channel_counter[k] = dn[k] ? r.channel_counter[k] - 16'h0001
					: r.channel_counter[k] + 16'h0001;
		end

		// Compare match toggles the pin level of that general register.
		n.pin_level = r.pin_level ^ match; // R11 R12

		// ==========================================================
		// APB slave: setup cycle prepares the answer, access phase completes with pready.
		n.ready = 1'b0;
		n.slverr = 1'b0;
		if (psel && !penable)
		begin
			n.ready = 1'b1;
			n.rdata = 32'h0000_0000;
			if (paddr[1:0] != 2'h0)
				n.slverr = 1'b1;
			else if (paddr <= tcs_pkg::CTRL2_OFS)
				n.rdata[7:0] = r.counter_control[word[1:0]];
			else if (paddr >= tcs_pkg::MODE0_OFS && paddr <= tcs_pkg::MODE2_OFS)
				n.rdata[7:0] = r.channel_mode_reg[3'(word - 5'h03)];
			else if (paddr == tcs_pkg::RUN_OFS)
				n.rdata[2:0] = r.counter_run_control;
			else if (paddr == tcs_pkg::SYNC_OFS)
				n.rdata[2:0] = r.channel_sync_control;
			else if (paddr >= tcs_pkg::CNT0_OFS && paddr <= tcs_pkg::CNT2_OFS)
				n.rdata[15:0] = r.channel_counter[2'(word - 5'h08)];
			else if (paddr >= tcs_pkg::GR_BASE_OFS && paddr < tcs_pkg::IOC_BASE_OFS)
				n.rdata[15:0] = r.general_reg[3'(word - 5'h0C)];
			else if (paddr >= tcs_pkg::IOC_BASE_OFS && paddr < tcs_pkg::PIN_STAT_OFS)
				n.rdata[7:0] = r.pin_function_control[2'(word - 5'h14)];
			else if (paddr == tcs_pkg::PIN_STAT_OFS)
				n.rdata[7:0] = pin_in;
			else
				n.slverr = 1'b1;
		end

		// Writes land only on the completing edge of the access phase.
		if (psel && penable && r.ready && pwrite && !r.slverr) // R2
		begin
			if (paddr <= tcs_pkg::CTRL2_OFS)
				n.counter_control[word[1:0]] = (word == 5'h00) ? pwdata[7:0]
					: (pwdata[7:0] & tcs_pkg::RESERVED_BIT7_MASK); // R18
			else if (paddr >= tcs_pkg::MODE0_OFS && paddr <= tcs_pkg::MODE2_OFS)
				n.channel_mode_reg[3'(word - 5'h03)] = pwdata[7:0];
			else if (paddr == tcs_pkg::RUN_OFS)
				n.counter_run_control = pwdata[2:0];
			else if (paddr == tcs_pkg::SYNC_OFS)
				n.channel_sync_control = pwdata[2:0];
			else if (paddr >= tcs_pkg::CNT0_OFS && paddr <= tcs_pkg::CNT2_OFS)
				n.channel_counter[2'(word - 5'h08)] = pwdata[15:0];
			else if (paddr >= tcs_pkg::GR_BASE_OFS && paddr < tcs_pkg::IOC_BASE_OFS)
				n.general_reg[3'(word - 5'h0C)] = pwdata[15:0];
			else if (paddr >= tcs_pkg::IOC_BASE_OFS && paddr < tcs_pkg::PIN_STAT_OFS)
				n.pin_function_control[2'(word - 5'h14)] = pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r.counter_control <= {3{tcs_pkg::CTRL_RST}};
			r.channel_mode_reg <= {3{tcs_pkg::MODE_RST}};
			r.counter_run_control <= tcs_pkg::RUN_RST;
			r.channel_sync_control <= tcs_pkg::SYNC_RST;
			r.channel_counter <= {3{tcs_pkg::CNT_RST}};
			r.general_reg <= {8{tcs_pkg::GR_RST}};
			r.pin_function_control <= {4{tcs_pkg::IOC_RST}};
			r.pin_level <= 8'h00;
			r.rdata <= 32'h0000_0000;
			r.ready <= 1'b0;
			r.slverr <= 1'b0;
		end
		else
			r <= n;
	end

	// ==========================================================
	// Outputs, all straight from the state register
	assign prdata = r.rdata;
	assign pready = r.ready;
	assign pslverr = r.slverr;
	assign ch0_pin_a_out = r.pin_level[0]; // R11
	assign ch0_pin_b_out = r.pin_level[1];
	assign ch0_pin_c_out = r.pin_level[2];
	assign ch0_pin_d_out = r.pin_level[3];
	assign ch1_pin_a_out = r.pin_level[4]; // R12
	assign ch1_pin_b_out = r.pin_level[5];
	assign ch2_pin_a_out = r.pin_level[6];
	assign ch2_pin_b_out = r.pin_level[7];
	assign ch0_pin_a_oe = r.pin_function_control[0][tcs_pkg::IOC_OE_LO];
	assign ch0_pin_b_oe = r.pin_function_control[0][tcs_pkg::IOC_OE_HI];
	assign ch0_pin_c_oe = r.pin_function_control[1][tcs_pkg::IOC_OE_LO];
	assign ch0_pin_d_oe = r.pin_function_control[1][tcs_pkg::IOC_OE_HI];
	assign ch1_pin_a_oe = r.pin_function_control[2][tcs_pkg::IOC_OE_LO];
	assign ch1_pin_b_oe = r.pin_function_control[2][tcs_pkg::IOC_OE_HI];
	assign ch2_pin_a_oe = r.pin_function_control[3][tcs_pkg::IOC_OE_LO];
	assign ch2_pin_b_oe = r.pin_function_control[3][tcs_pkg::IOC_OE_HI];

endmodule

// ===== dv/tcs_timer_properties.sv
// Checker with bus-timing, refusal and pin-enable properties of the timer unit.
`timescale 1ns/1ns
module tcs_timer_chk
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ch0_pin_a_oe,
	input wire logic ch2_pin_b_oe
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic setup;
	logic bad;
	logic rd_done;
	logic wr_ioc0;
	logic wr_ioc2;
	assign setup = psel && !penable;
	assign bad = paddr[1:0] != 2'h0 || paddr == 8'h2C || paddr > 8'h60;
	assign rd_done = pready && !pwrite && !pslverr;
	assign wr_ioc0 = pready && pwrite && paddr == 8'h50;
	assign wr_ioc2 = pready && pwrite && paddr == 8'h5C;
	// ==========
	// Bus answer
	a_zero_wait: assert property (setup |=> pready && penable)
		else $error("no ready in first access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_bad_refused: assert property (setup && bad |=> pslverr)
		else $error("unmapped address accepted");
	a_good_taken: assert property (setup && !bad |=> !pslverr)
		else $error("mapped address refused");
	a_err_data_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_ctrl_narrow: assert property (rd_done && paddr <= 8'h08 |-> prdata[31:8] == 24'h0)
		else $error("control read has upper bits");
	a_bit7_zero: assert property (rd_done && paddr inside {8'h04, 8'h08} |-> !prdata[7])
		else $error("reserved control bit reads one");
	// ==========
	// Pin enables move only after a write of their control register
	a_oe0_by_write: assert property ($changed(ch0_pin_a_oe) |-> $past(wr_ioc0) || $past(wr_ioc0, 2))
		else $error("channel 0 pin enable changed alone");
	a_oe2_by_write: assert property ($changed(ch2_pin_b_oe) |-> $past(wr_ioc2) || $past(wr_ioc2, 2))
		else $error("channel 2 pin enable changed alone");
	c_refused: cover property (pready && pslverr);
	c_ctrl1_read: cover property (rd_done && paddr == 8'h04);
	c_oe_on: cover property ($rose(ch0_pin_a_oe));
endmodule
bind tcs_timer tcs_timer_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .ch0_pin_a_oe(ch0_pin_a_oe), .ch2_pin_b_oe(ch2_pin_b_oe));

// ===== dv/tcs_far_model.sv
// Far-side model: external clock sources and the drivers of the shared pins.
`timescale 1ns/1ns
module tcs_far_model
(
	input wire logic pclk,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_drv,
	output logic [3:0] ext_clk,
	output logic [7:0] pin_in
);
	initial
	begin
		ext_clk = 4'h0;
	end
	// Where the timer enables its driver the wire carries its level, else the model's.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_drv);
	// ==========
	// Bursts: clocks idle low between them; each quarter period lasts two cycles.
	task automatic burst(input int idx, input int n, input bit quad);
		for (int i = 0; i < 4 * n; i++)
		begin
			repeat (2) @(posedge pclk);
			if (quad)
				ext_clk[idx + i % 2] <= ~ext_clk[idx + i % 2];
			else if (i % 2 == 0)
				ext_clk[idx] <= ~ext_clk[idx];
		end
	endtask
endmodule

// ===== dv/tcs_timer_tb_top.sv
// Self-checking testbench of the three-channel timer unit.
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
	begin \
		checks_done++; \
		if ((got) !== (ex)) \
		begin \
			n_fail++; \
			$display("unexpected %s: expected %h seen %h", nm, ex, got); \
		end \
	end
module tcs_timer_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] ext_clk;
	logic [7:0] pin_in;
	logic [7:0] pin_out;
	logic [7:0] pin_oe;
	logic [7:0] pin_drv = 8'h00;
	logic [31:0] rd;
	logic err;
	int n_fail = 0;
	int checks_done = 0;
	always #5 pclk = ~pclk;
	tcs_far_model model (.pclk(pclk), .pin_oe(pin_oe), .pin_out(pin_out), .pin_drv(pin_drv),
		.ext_clk(ext_clk), .pin_in(pin_in));
	tcs_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_clock_in_a(ext_clk[0]), .ext_clock_in_b(ext_clk[1]),
		.ext_clock_in_c(ext_clk[2]), .ext_clock_in_d(ext_clk[3]),
		.ch0_pin_a_in(pin_in[0]), .ch0_pin_a_out(pin_out[0]), .ch0_pin_a_oe(pin_oe[0]),
		.ch0_pin_b_in(pin_in[1]), .ch0_pin_b_out(pin_out[1]), .ch0_pin_b_oe(pin_oe[1]),
		.ch0_pin_c_in(pin_in[2]), .ch0_pin_c_out(pin_out[2]), .ch0_pin_c_oe(pin_oe[2]),
		.ch0_pin_d_in(pin_in[3]), .ch0_pin_d_out(pin_out[3]), .ch0_pin_d_oe(pin_oe[3]),
		.ch1_pin_a_in(pin_in[4]), .ch1_pin_a_out(pin_out[4]), .ch1_pin_a_oe(pin_oe[4]),
		.ch1_pin_b_in(pin_in[5]), .ch1_pin_b_out(pin_out[5]), .ch1_pin_b_oe(pin_oe[5]),
		.ch2_pin_a_in(pin_in[6]), .ch2_pin_a_out(pin_out[6]), .ch2_pin_a_oe(pin_oe[6]),
		.ch2_pin_b_in(pin_in[7]), .ch2_pin_b_out(pin_out[7]), .ch2_pin_b_oe(pin_oe[7]));
	// ==========
	// Bus master and closing report
	task automatic stop_test(input bit hung);
		if (hung)
			n_fail++;
		$display("comparisons %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (k == 20)
			stop_test(1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so that a following call never drives psel twice in one time step.
		@(posedge pclk);
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic r(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	// Counts over a window of whole prescaler periods, or over a burst of the far side.
	task automatic measure(input int ch, input logic [7:0] ctrl, input int win, input int src,
		input bit quad, input logic [15:0] ex);
		w(8'(tcs_pkg::CNT0_OFS + 4 * ch), 32'h0);
		w(8'(tcs_pkg::CTRL0_OFS + 4 * ch), {24'h0, ctrl});
		w(8'(tcs_pkg::MODE0_OFS + 4 * ch), {31'h0, quad});
		w(tcs_pkg::RUN_OFS, 32'(1 << ch));
		if (src < 0)
			repeat (win - 3) @(posedge pclk);
		else
		begin
			model.burst(src, win, quad);
			repeat (8) @(posedge pclk);
		end
		w(tcs_pkg::RUN_OFS, 32'h0);
		r(8'(tcs_pkg::CNT0_OFS + 4 * ch));
		`CHK("count", ex, rd[15:0])
	endtask
	// ==========
	// Scenarios
	task automatic t_reset();
		for (int i = 0; i < 8; i++)
		begin
			r(8'(tcs_pkg::GR_BASE_OFS + 4 * i));
			`CHK("general reset", 32'hFFFF, rd)
			r(8'(tcs_pkg::CTRL0_OFS + 4 * (i % 3)));
			`CHK("control reset", 32'h0, rd)
		end
	endtask
	task automatic t_regs();
		for (int ch = 0; ch < 3; ch++)
		begin
			w(8'(tcs_pkg::CTRL0_OFS + 4 * ch), 32'hFFFFFFFF);
			r(8'(tcs_pkg::CTRL0_OFS + 4 * ch));
			`CHK("control readback", (ch == 0) ? 32'hFF : 32'h7F, rd)
			w(8'(tcs_pkg::CTRL0_OFS + 4 * ch), 32'h0);
		end
	endtask
	task automatic t_bad();
		logic [7:0] bad [3] = '{8'h2C, 8'h01, 8'h64};
		for (int i = 0; i < 3; i++)
		begin
			apb(i[0], bad[i], 32'h5A);
			`CHK("refusal", 33'h100000000, {err, rd})
		end
		r(tcs_pkg::CTRL0_OFS);
		`CHK("control after refusal", 32'h0, rd)
	endtask
	task automatic t_pins();
		pin_drv <= 8'hFF;
		repeat (4) @(posedge pclk);
		r(tcs_pkg::PIN_STAT_OFS);
		`CHK("pin levels high", 8'hFF, rd[7:0])
		pin_drv <= 8'h00;
		repeat (4) @(posedge pclk);
		r(tcs_pkg::PIN_STAT_OFS);
		`CHK("pin levels low", 8'h00, rd[7:0])
		for (int i = 0; i < 4; i++)
			w(8'(tcs_pkg::IOC_BASE_OFS + 4 * i), 32'h11);
		repeat (2) @(posedge pclk);
		`CHK("pin enables", 8'hFF, pin_oe)
		for (int i = 0; i < 4; i++)
			w(8'(tcs_pkg::IOC_BASE_OFS + 4 * i), 32'h0);
	endtask
	task automatic t_clocks();
		measure(0, 8'h00, 64, -1, 1'b0, 16'h40);
		measure(0, 8'h08, 64, -1, 1'b0, 16'h40);
		measure(0, 8'h01, 64, -1, 1'b0, 16'h10);
		measure(0, 8'h09, 64, -1, 1'b0, 16'h10);
		measure(0, 8'h11, 64, -1, 1'b0, 16'h20);
		measure(0, 8'h02, 64, -1, 1'b0, 16'h4);
		measure(0, 8'h03, 64, -1, 1'b0, 16'h1);
		measure(1, 8'h06, 256, -1, 1'b0, 16'h1);
		measure(1, 8'h07, 64, -1, 1'b0, 16'h0);
		measure(2, 8'h07, 1024, -1, 1'b0, 16'h1);
		measure(2, 8'h03, 64, -1, 1'b0, 16'h1);
	endtask
	task automatic t_ext();
		for (int i = 0; i < 4; i++)
			measure(0, {3'h0, 2'(i), 3'(4 + i)}, 5, i, 1'b0, (i < 2) ? 16'h5 : 16'hA);
		measure(1, 8'h05, 5, 1, 1'b0, 16'h5);
		measure(2, 8'h06, 5, 2, 1'b0, 16'h5);
		measure(1, 8'h0F, 5, 0, 1'b1, 16'h14);
		measure(2, 8'h0F, 5, 2, 1'b1, 16'h14);
	endtask
	task automatic t_clear();
		for (int i = 0; i < 4; i++)
			w(8'(tcs_pkg::GR_BASE_OFS + 4 * i), 32'h9);
		for (int c = 0; c < 7; c++)
		begin
			if (c != 3)
			begin
				measure(0, {3'(c), 5'h0}, 64, -1, 1'b0, (c % 4 == 0) ? 16'h40 : 16'h4);
				// All four registers hold 9, so each pin toggles once per pass through 9.
				`CHK("compare pin levels", (c < 4) ? 4'hF : 4'h0, pin_out[3:0])
			end
		end
	endtask
	task automatic t_sync();
		w(tcs_pkg::GR_BASE_OFS, 32'h9);
		w(tcs_pkg::CNT0_OFS, 32'h0);
		w(tcs_pkg::CNT1_OFS, 32'h0);
		w(tcs_pkg::MODE1_OFS, 32'h0);
		w(tcs_pkg::SYNC_OFS, 32'h3);
		w(tcs_pkg::CTRL0_OFS, 32'h20);
		w(tcs_pkg::CTRL1_OFS, 32'h60);
		w(tcs_pkg::RUN_OFS, 32'h3);
		repeat (61) @(posedge pclk);
		w(tcs_pkg::RUN_OFS, 32'h0);
		r(tcs_pkg::CNT1_OFS);
		`CHK("synchronised clear", 16'h4, rd[15:0])
	endtask
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_regs();
		t_bad();
		t_pins();
		t_clocks();
		t_ext();
		t_clear();
		t_sync();
		stop_test(1'b0);
	end
endmodule
